/* File: servo_stop_sequence_switch_test.sv */
`timescale 1ns/1ps
`default_nettype none
module servo_stop_sequence_switch_test;
	logic        clock = 1'h0;
	logic        rst_n = 1'h0;
	logic        psel = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite = 1'h0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        alarm = 1'h0;
	logic        forwardTravelLimit = 1'h0;
	logic        reverseTravelLimit = 1'h0;
	logic [15:0] torqueRef = 16'h0, speedRef = 16'h0, accelRef = 16'h0, errorPulse = 16'h0;
	logic [7:0]  delay = 8'h05;
	logic        pready, pslverr, motorStopped, dynBrake, coast, torqueDecel;
	logic        zeroClamp, servoOff, fwdInhibit, revInhibit, modeSwitch, irq, errSeen;
	logic [31:0] prdata, rd;
	logic [15:0] stopTorque, sw, lvl;
	int          err_total = 0;
	int          checks = 0;
	always #12.5 clock = ~clock;
	sss_stop_seq dut_u (.clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pready, .prdata, .pslverr, .alarm, .forwardTravelLimit, .reverseTravelLimit,
		.motorStopped, .torqueRef, .speedRef, .accelRef, .errorPulse, .dynBrake, .coast,
		.torqueDecel, .stopTorque, .zeroClamp, .servoOff, .fwdInhibit, .revInhibit,
		.modeSwitch, .irq);
	sss_motor_model model_u (.clock, .rst_n, .dynBrake, .coast, .torqueDecel, .servoOff,
		.zeroClamp, .delay, .motorStopped);
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_sim
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wt(input int n);
		repeat (n) @(posedge clock);
	endtask : wt
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clock);
		psel <= 1'h1; penable <= 1'h0; pwrite <= wr; paddr <= a; pwdata <= d;
		@(posedge clock);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'h1 && n < 20);
		if (n >= 20) begin
			err_total++;
			end_sim();
		end
		rd = prdata;
		errSeen = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task automatic until_stop;
		int n;
		n = 0;
		while (motorStopped !== 1'h1 && n < 300) begin
			@(posedge clock);
			n++;
		end
		if (n >= 300) begin
			err_total++;
			end_sim();
		end
	endtask : until_stop
	task automatic set_ref(input int t, input logic [15:0] v);
		torqueRef <= (t == 0) ? v : 16'h0;
		speedRef <= (t == 1) ? v : 16'h0;
		accelRef <= (t == 2) ? v : 16'h0;
		errorPulse <= (t == 3) ? v : 16'h0;
	endtask : set_ref
	// Returns {dynBrake, coast, torqueDecel} while the motor runs down
	function automatic logic [2:0] stop_exp(input logic [15:0] s, input logic al);
		if (!al && s[8])
			return 3'h1;
		return s[6] ? 3'h2 : 3'h4;
	endfunction : stop_exp
	initial begin
		wt(100000);
		err_total++;
		end_sim();
	end
	initial begin
		void'($urandom(15));
		wt(20);
		rst_n <= 1'h1;
		apb(1'h0, sss_pkg::ADDR_SWITCH, 32'h0);
		chk("switch reset", rd, {16'h0, sss_pkg::SWITCH_RESET});
		apb(1'h0, 8'h18, 32'h0);
		chk("unmapped err", errSeen, 32'h1);
		lvl = 16'($urandom);
		apb(1'h1, sss_pkg::ADDR_STOP_TORQ, {16'h0, lvl});
		wt(2);
		chk("stop torque", stopTorque, lvl);
		$display("register test done");
		for (int i = 0; i < 4; i++) begin
			apb(1'h1, sss_pkg::ADDR_SWITCH, 32'(i % 2) << 3);
			reverseTravelLimit <= i[1];
			wt(3);
			chk("rev inhibit", revInhibit, !i[0] & i[1]);
			reverseTravelLimit <= 1'h0;
			wt(6);
		end
		$display("reverse limit test done");
		for (int i = 0; i < 32; i++) begin
			sw = 16'(i % 16) << 6;
			apb(1'h1, sss_pkg::ADDR_SWITCH, {16'h0, sw});
			delay <= 8'($urandom_range(6, 20));
			if (i[4])
				alarm <= 1'h1;
			else if ($urandom % 2)
				forwardTravelLimit <= 1'h1;
			else
				reverseTravelLimit <= 1'h1;
			wt(3);
			chk("stop kind", {dynBrake, coast, torqueDecel}, stop_exp(sw, i[4]));
			chk("limit inhibit", {fwdInhibit, revInhibit},
				{forwardTravelLimit, reverseTravelLimit});
			until_stop();
			wt(3);
			chk("brake held", dynBrake, i[4] & !sw[6] & sw[7]);
			chk("zero clamp", zeroClamp, !i[4] & sw[8] & sw[9]);
			chk("servo off", servoOff, !(!i[4] & sw[8] & sw[9]));
			alarm <= 1'h0;
			forwardTravelLimit <= 1'h0;
			reverseTravelLimit <= 1'h0;
			wt(4);
		end
		$display("stop sequence test done");
		apb(1'h1, sss_pkg::ADDR_IRQ_MASK, 32'hf);
		apb(1'h0, sss_pkg::ADDR_IRQ_STAT, 32'h0);
		delay <= 8'hc8;
		alarm <= 1'h1;
		wt(3);
		chk("irq raised", irq, 32'h1);
		apb(1'h0, sss_pkg::ADDR_IRQ_STAT, 32'h0);
		chk("alarm event", rd[0], 32'h1);
		apb(1'h0, sss_pkg::ADDR_IRQ_STAT, 32'h0);
		wt(2);
		chk("irq cleared", {rd[3:0], irq}, 32'h0);
		apb(1'h1, sss_pkg::ADDR_IRQ_MASK, 32'h0);
		alarm <= 1'h0;
		until_stop();
		delay <= 8'h05;
		wt(4);
		alarm <= 1'h1;
		wt(3);
		chk("irq masked", irq, 32'h0);
		apb(1'h0, sss_pkg::ADDR_IRQ_STAT, 32'h0);
		chk("masked event", rd[0], 32'h1);
		alarm <= 1'h0;
		until_stop();
		wt(4);
		$display("interrupt test done");
		lvl = 16'($urandom_range(16'h1000, 16'hf000));
		apb(1'h1, sss_pkg::ADDR_TRIG_LEVEL, {16'h0, lvl});
		for (int t = 0; t < 4; t++) begin
			apb(1'h1, sss_pkg::ADDR_SWITCH, 32'(t) << 12);
			set_ref(t, lvl);
			wt(4);
			chk("mode at level", modeSwitch, 32'h0);
			set_ref(t, lvl + 16'h1);
			wt(4);
			chk("mode above", modeSwitch, 32'h1);
			apb(1'h1, sss_pkg::ADDR_SWITCH, (32'(t) << 12) | 32'h800);
			wt(4);
			chk("mode off", modeSwitch, 32'h0);
		end
		$display("mode switch test done");
		end_sim();
	end
endmodule : servo_stop_sequence_switch_test
`default_nettype wire

/* File: sss_mode_trigger.sv */
`timescale 1ns/1ps
`default_nettype none
module sss_mode_trigger (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        modeOff,
	input  wire logic [1:0]  trigSel,
	input  wire logic [15:0] level,
	input  wire logic [15:0] torqueRef,
	input  wire logic [15:0] speedRef,
	input  wire logic [15:0] accelRef,
	input  wire logic [15:0] errorPulse,
	output logic             modeActive
);
	logic [15:0] sample;

	always_comb begin
		case (sss_pkg::sss_trig_t'(trigSel))
			sss_pkg::TRIG_TORQUE: sample = torqueRef;
			sss_pkg::TRIG_SPEED:  sample = speedRef;
			sss_pkg::TRIG_ACCEL:  sample = accelRef;
			sss_pkg::TRIG_ERROR:  sample = errorPulse;
			default:              sample = torqueRef;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			modeActive <= 1'b0;
		end else begin
			modeActive <= !modeOff && (sample > level);
		end
	end

	a_mode_disable: assert property (@(posedge clock) disable iff (!rst_n)
		modeOff |=> !modeActive)
		else $error("mode switch active while disabled");
endmodule : sss_mode_trigger
`default_nettype wire

/* File: sss_motor_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sss_motor_model (
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic       dynBrake,
	input  wire logic       coast,
	input  wire logic       torqueDecel,
	input  wire logic       servoOff,
	input  wire logic       zeroClamp,
	input  wire logic [7:0] delay,
	output logic            motorStopped
);
	logic [7:0] cnt_reg;
	// Standstill comes a settable run-down time after any stop command
	always_ff @(posedge clock) begin
		if (!rst_n || !(dynBrake | coast | torqueDecel | servoOff | zeroClamp))
			cnt_reg <= 8'h00;
		else if (cnt_reg != delay)
			cnt_reg <= cnt_reg + 8'h01;
	end
	assign motorStopped = (cnt_reg == delay);
endmodule : sss_motor_model
`default_nettype wire

/* File: sss_pkg.sv */
package sss_pkg;
	localparam logic [7:0]  ADDR_SWITCH     = 8'h00;
	localparam logic [7:0]  ADDR_STOP_TORQ  = 8'h04;
	localparam logic [7:0]  ADDR_TRIG_LEVEL = 8'h08;
	localparam logic [7:0]  ADDR_STATUS     = 8'h0c;
	localparam logic [7:0]  ADDR_IRQ_STAT   = 8'h10;
	localparam logic [7:0]  ADDR_IRQ_MASK   = 8'h14;
	localparam logic [15:0] SWITCH_RESET    = 16'h0080;
	localparam int          BIT_REV_IGNORE  = 3;
	localparam int          BIT_ALARM_COAST = 6;
	localparam int          BIT_BRAKE_HOLD  = 7;
	localparam int          BIT_OT_DECEL    = 8;
	localparam int          BIT_OT_CLAMP    = 9;
	localparam int          BIT_MODE_OFF    = 11;
	localparam int          BIT_TRIG_LO     = 12;
	localparam int          BIT_TRIG_HI     = 13;
	localparam logic [15:0] STOP_TORQ_RESET = 16'h0000;
	localparam logic [15:0] TRIG_RESET      = 16'h00c8;
	localparam int          N_EVENTS        = 4;
	typedef enum logic [1:0] {
		ST_RUN   = 2'b00,
		ST_STOP  = 2'b01,
		ST_HELD  = 2'b11,
		ST_FREE  = 2'b10
	} sss_state_t;
	typedef enum logic [1:0] {
		TRIG_TORQUE = 2'b00,
		TRIG_SPEED  = 2'b01,
		TRIG_ACCEL  = 2'b10,
		TRIG_ERROR  = 2'b11
	} sss_trig_t;
endpackage : sss_pkg

/* File: sss_stop_seq.sv */
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module sss_stop_seq (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic        alarm,
	input  wire logic        forwardTravelLimit,
	input  wire logic        reverseTravelLimit,
	input  wire logic        motorStopped,
	input  wire logic [15:0] torqueRef,
	input  wire logic [15:0] speedRef,
	input  wire logic [15:0] accelRef,
	input  wire logic [15:0] errorPulse,
	output logic             dynBrake,
	output logic             coast,
	output logic             torqueDecel,
	output logic [15:0]      stopTorque,
	output logic             zeroClamp,
	output logic             servoOff,
	output logic             fwdInhibit,
	output logic             revInhibit,
	output logic             modeSwitch,
	output logic             irq
);
	logic [15:0] switch_reg;
	logic [15:0] stopTorque_reg;
	logic [15:0] trigLevel_reg;
	logic [3:0]  irqStat_reg;
	logic [3:0]  irqMask_reg;
	logic [3:0]  irqEvents;
	logic        alarm_reg;
	logic        ot_reg;
	logic        otDecel_reg;
	logic        modeActive;
	logic        modeActive_reg;
	logic        revLimitUsed;
	logic        otNow;
	logic        wrEn;
	logic        rdEn;
	logic        mapped;
	logic        statRead;
	sss_pkg::sss_state_t state_reg;
	sss_pkg::sss_state_t state_next;

	assign wrEn     = psel && penable && pwrite;
	assign rdEn     = psel && penable && !pwrite;
	assign statRead = rdEn && (paddr == sss_pkg::ADDR_IRQ_STAT);
	assign mapped   = (paddr == sss_pkg::ADDR_SWITCH) || (paddr == sss_pkg::ADDR_STOP_TORQ)
		|| (paddr == sss_pkg::ADDR_TRIG_LEVEL) || (paddr == sss_pkg::ADDR_STATUS)
		|| (paddr == sss_pkg::ADDR_IRQ_STAT) || (paddr == sss_pkg::ADDR_IRQ_MASK);
	// Reverse limit counts only when the switch says the input is used
	assign revLimitUsed = !switch_reg[sss_pkg::BIT_REV_IGNORE] && reverseTravelLimit;
	assign otNow        = forwardTravelLimit || revLimitUsed;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			switch_reg     <= sss_pkg::SWITCH_RESET;
			stopTorque_reg <= sss_pkg::STOP_TORQ_RESET;
			trigLevel_reg  <= sss_pkg::TRIG_RESET;
			irqMask_reg    <= '0;
		end else if (wrEn) begin
			case (paddr)
				sss_pkg::ADDR_SWITCH:     switch_reg     <= pwdata[15:0];
				sss_pkg::ADDR_STOP_TORQ:  stopTorque_reg <= pwdata[15:0];
				sss_pkg::ADDR_TRIG_LEVEL: trigLevel_reg  <= pwdata[15:0];
				sss_pkg::ADDR_IRQ_MASK:   irqMask_reg    <= pwdata[3:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			prdata  <= '0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			prdata  <= '0;
			if (psel && !penable && !pwrite) begin
				case (paddr)
					sss_pkg::ADDR_SWITCH:     prdata <= {16'h0000, switch_reg};
					sss_pkg::ADDR_STOP_TORQ:  prdata <= {16'h0000, stopTorque_reg};
					sss_pkg::ADDR_TRIG_LEVEL: prdata <= {16'h0000, trigLevel_reg};
					sss_pkg::ADDR_STATUS:     prdata <= {26'h0, modeActive, otNow, alarm_reg,
						otDecel_reg, state_reg};
					// Events of this edge are shown too, as the read clears them next edge
					sss_pkg::ADDR_IRQ_STAT:   prdata <= {28'h0, irqStat_reg | irqEvents};
					sss_pkg::ADDR_IRQ_MASK:   prdata <= {28'h0, irqMask_reg};
					default:                  prdata <= '0;
				endcase
			end
		end
	end

	// Stop sequence: run, stopping, stopped and held (brake after alarm, zero clamp after overtravel), stopped and free
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			sss_pkg::ST_RUN:  if (alarm || otNow) state_next = sss_pkg::ST_STOP;
			sss_pkg::ST_STOP: begin
				if (motorStopped) begin
					if (alarm_reg && switch_reg[sss_pkg::BIT_BRAKE_HOLD]
						&& !switch_reg[sss_pkg::BIT_ALARM_COAST])
						state_next = sss_pkg::ST_HELD;
					else if (!alarm_reg && otDecel_reg && switch_reg[sss_pkg::BIT_OT_CLAMP])
						state_next = sss_pkg::ST_HELD;
					else
						state_next = sss_pkg::ST_FREE;
				end
			end
			sss_pkg::ST_HELD, sss_pkg::ST_FREE: if (!alarm && !otNow) state_next = sss_pkg::ST_RUN;
			default: state_next = sss_pkg::ST_RUN;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_reg   <= sss_pkg::ST_RUN;
			alarm_reg   <= 1'b0;
			ot_reg      <= 1'b0;
			otDecel_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (state_reg == sss_pkg::ST_RUN && state_next == sss_pkg::ST_STOP) begin
				alarm_reg   <= alarm;
				ot_reg      <= !alarm;
				otDecel_reg <= !alarm && switch_reg[sss_pkg::BIT_OT_DECEL];
			end else if (state_next == sss_pkg::ST_RUN) begin
				alarm_reg   <= 1'b0;
				ot_reg      <= 1'b0;
				otDecel_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			dynBrake    <= 1'b0;
			coast       <= 1'b0;
			torqueDecel <= 1'b0;
			stopTorque  <= '0;
			zeroClamp   <= 1'b0;
			servoOff    <= 1'b0;
			fwdInhibit  <= 1'b0;
			revInhibit  <= 1'b0;
		end else begin
			dynBrake    <= 1'b0;
			coast       <= 1'b0;
			torqueDecel <= 1'b0;
			zeroClamp   <= 1'b0;
			servoOff    <= 1'b0;
			stopTorque  <= stopTorque_reg;
			fwdInhibit  <= forwardTravelLimit;
			revInhibit  <= revLimitUsed;
			case (state_next)
				sss_pkg::ST_STOP: begin
					if (otDecel_reg || (state_reg == sss_pkg::ST_RUN && !alarm
						&& switch_reg[sss_pkg::BIT_OT_DECEL]))
						torqueDecel <= 1'b1;
					else if (switch_reg[sss_pkg::BIT_ALARM_COAST]) begin
						coast    <= 1'b1;
						servoOff <= 1'b1;
					end else begin
						dynBrake <= 1'b1;
						servoOff <= 1'b1;
					end
				end
				sss_pkg::ST_HELD: begin
					if (alarm_reg) begin
						dynBrake <= 1'b1;
						servoOff <= 1'b1;
					end else
						zeroClamp <= 1'b1;
				end
				sss_pkg::ST_FREE: servoOff <= 1'b1;
				default: ;
			endcase
		end
	end

	sss_mode_trigger u_trig (
		.clock      (clock),
		.rst_n      (rst_n),
		.modeOff    (switch_reg[sss_pkg::BIT_MODE_OFF]),
		.trigSel    (switch_reg[sss_pkg::BIT_TRIG_HI:sss_pkg::BIT_TRIG_LO]),
		.level      (trigLevel_reg),
		.torqueRef  (torqueRef),
		.speedRef   (speedRef),
		.accelRef   (accelRef),
		.errorPulse (errorPulse),
		.modeActive (modeActive)
	);

	// Events: alarm stop, overtravel stop, motor stopped, mode switch rise
	assign irqEvents = {modeActive && !modeActive_reg,
		state_reg == sss_pkg::ST_STOP && motorStopped,
		state_reg == sss_pkg::ST_RUN && !alarm && otNow,
		state_reg == sss_pkg::ST_RUN && alarm};

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			irqStat_reg    <= '0;
			modeActive_reg <= 1'b0;
			modeSwitch     <= 1'b0;
			irq            <= 1'b0;
		end else begin
			modeActive_reg <= modeActive;
			modeSwitch     <= modeActive;
			irqStat_reg    <= (statRead ? 4'h0 : irqStat_reg) | irqEvents;
			irq            <= |(((statRead ? 4'h0 : irqStat_reg) | irqEvents) & irqMask_reg);
		end
	end

	a_rev_ignored: assert property (@(posedge clock) disable iff (!rst_n)
		switch_reg[sss_pkg::BIT_REV_IGNORE] && !forwardTravelLimit && !alarm
		&& state_reg == sss_pkg::ST_RUN |=> !revInhibit && state_reg == sss_pkg::ST_RUN)
		else $error("reverse limit honoured while ignored");
	a_alarm_brake: assert property (@(posedge clock) disable iff (!rst_n)
		state_reg == sss_pkg::ST_RUN && alarm && !switch_reg[sss_pkg::BIT_ALARM_COAST]
		|=> dynBrake && !coast)
		else $error("alarm did not apply dynamic brake");
	a_alarm_coast: assert property (@(posedge clock) disable iff (!rst_n)
		state_reg == sss_pkg::ST_RUN && alarm && switch_reg[sss_pkg::BIT_ALARM_COAST]
		|=> coast && !dynBrake)
		else $error("alarm did not coast");
	a_brake_hold: assert property (@(posedge clock) disable iff (!rst_n)
		state_reg == sss_pkg::ST_HELD && alarm_reg |-> dynBrake || $past(state_reg)
		!= sss_pkg::ST_HELD)
		else $error("brake released in hold");
	a_ot_decel: assert property (@(posedge clock) disable iff (!rst_n)
		state_reg == sss_pkg::ST_RUN && !alarm && otNow && switch_reg[sss_pkg::BIT_OT_DECEL]
		|=> torqueDecel && !dynBrake && !coast)
		else $error("overtravel did not decelerate");
	a_ot_clamp: assert property (@(posedge clock) disable iff (!rst_n)
		state_reg == sss_pkg::ST_STOP && motorStopped && otDecel_reg && !alarm_reg
		&& switch_reg[sss_pkg::BIT_OT_CLAMP] |=> zeroClamp && !servoOff)
		else $error("no zero clamp after decel");
	a_ot_off: assert property (@(posedge clock) disable iff (!rst_n)
		state_reg == sss_pkg::ST_STOP && motorStopped && otDecel_reg && !alarm_reg
		&& !switch_reg[sss_pkg::BIT_OT_CLAMP] |=> servoOff && !zeroClamp)
		else $error("servo not off after decel");
	a_irq_level: assert property (@(posedge clock) disable iff (!rst_n)
		irq == $past(|(((statRead ? 4'h0 : irqStat_reg) | irqEvents) & irqMask_reg))
		|| $past(!rst_n))
		else $error("interrupt out of step");
	c_alarm_held: cover property (@(posedge clock) state_reg == sss_pkg::ST_HELD && alarm_reg);
	c_ot_clamp: cover property (@(posedge clock) zeroClamp);
	c_coast: cover property (@(posedge clock) coast);
	c_mode: cover property (@(posedge clock) modeSwitch);
endmodule : sss_stop_seq
`default_nettype wire
